// [logic/bg_swap_pkg.sv]
package bg_swap_pkg;
	// ==========================================================
	// Register indices (printed offsets) and byte addresses
	localparam logic [9:0] idx_trim_c         = 10'h080;
	localparam logic [9:0] idx_trim_d         = 10'h081;
	localparam logic [9:0] idx_overlap        = 10'h09a;
	localparam logic [9:0] idx_mux_delay      = 10'h09b;
	localparam logic [9:0] idx_dither_control = 10'h09d;
	localparam logic [9:0] idx_lsb_control    = 10'h160;
	localparam int         addr_width         = 12;
	localparam int         byte_shift         = 2;

	// ==========================================================
	// Field layout and reset values
	localparam int         delay_width        = 5;
	localparam int         dither_enable_bit  = 0;
	localparam int         dither_amp_bit     = 1;
	localparam int         dither_err_bit     = 2;
	localparam logic [7:0] overlap_reset      = 8'h08;
	localparam logic [7:0] mux_delay_reset    = 8'h07;
	localparam logic [7:0] dither_reset       = 8'h00;
	localparam logic [7:0] lsb_reset          = 8'h00;
	localparam logic [7:0] overlap_base       = 8'h04;

	// ==========================================================
	// Swap timing and dither steering carriers
	typedef struct packed {
		logic [4:0] overlap;
		logic [4:0] mux_delay;
	} swap_timing_type;

	typedef struct packed {
		logic enable;
		logic large_amplitude;
		logic error_to_offset;
	} dither_setting_type;

	typedef struct packed {
		logic active;
		logic both_sampling;
		logic mux_select;
	} swap_status_type;
endpackage

// [logic/cycle_delay.sv]
`timescale 1ns/1ps
// Programmable delay line of a one-bit select, tap chosen by index.
module cycle_delay #(
	parameter int depth = 32
) (
	input  wire logic                     clk_sys,
	input  wire logic                     nrst,
	input  wire logic                     din,
	input  wire logic [$clog2(depth)-1:0] tap,
	output logic                          dout
);
	logic [depth-1:0] line;
	wire              tapped = (tap == '0) ? din : line[tap - 1'b1];

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			line <= '0;
			dout <= 1'b0;
		end else begin
			line <= {line[depth-2:0], din};
			dout <= tapped;
		end
	end
endmodule

// [logic/swap_sequencer.sv]
`timescale 1ns/1ps
// One background swap: overlap window, then steering select toggles after the mux delay.
module swap_sequencer (
	input  wire logic                         clk_sys,
	input  wire logic                         nrst,
	input  wire logic                         swap_request,
	input  wire bg_swap_pkg::swap_timing_type timing,
	output bg_swap_pkg::swap_status_type      status
);
	typedef enum logic [1:0] {idle, overlap, steer} phase_type;

	phase_type                         phase;
	logic [6:0]                        count;
	logic [4:0]                        held_mux_delay;
	logic                              select;
	logic                              delayed_select;
	// Overlap length 4 + 2 * setting
	wire  [6:0]                        overlap_len = 7'(bg_swap_pkg::overlap_base)
		+ {1'b0, timing.overlap, 1'b0};
	wire                               start  = (phase == idle) && swap_request;
	wire                               done   = (count == 7'h01);
	wire  [6:0]                        next_count = start ? overlap_len
		: (count != 7'h00) ? count - 7'h01 : 7'h00;

	cycle_delay #(.depth(32)) mux_delay_line (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.din     (select),
		.tap     (held_mux_delay),
		.dout    (delayed_select)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			phase          <= idle;
			count          <= 7'h00;
			held_mux_delay <= 5'h00;
			select         <= 1'b0;
			status         <= '0;
		end else begin
			count <= next_count;
			unique case (phase)
				idle: begin
					if (start) begin
						held_mux_delay <= timing.mux_delay;
						phase          <= overlap;
					end
				end
				overlap: begin
					if (done) begin
						select <= ~select;
						phase  <= steer;
					end
				end
				steer: begin
					if (count == 7'h00 && delayed_select == select) begin
						phase <= idle;
					end
				end
			endcase
			status.active        <= (phase != idle) || start;
			status.both_sampling <= start || (phase == overlap && !done);
			status.mux_select    <= delayed_select;
		end
	end
endmodule

// [logic/bg_swap_dither_control.sv]
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
// ==========================================================
module bg_swap_dither_control (
	input  wire logic                            clk_sys,
	input  wire logic                            nrst,
	input  wire logic [bg_swap_pkg::addr_width-1:0] paddr,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [31:0]                     pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic [31:0]                          prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic [7:0]                      factory_trim_c,
	input  wire logic [7:0]                      factory_trim_d,
	input  wire logic                            swap_request,
	output logic [7:0]                           input_c_trim,
	output logic [7:0]                           input_d_trim,
	output bg_swap_pkg::dither_setting_type      dither_setting,
	output bg_swap_pkg::swap_status_type         swap_status,
	output logic [7:0]                           lsb_control
);
	// ==========================================================
	// Registers
	logic [7:0]                     input_c_termination_trim;
	logic [7:0]                     input_d_termination_trim;
	logic [7:0]                     swap_overlap_delay;
	logic [7:0]                     swap_mux_select_delay;
	logic [7:0]                     dither_control;
	logic [7:0]                     sample_lsb_control_output;
	logic                           trim_loaded;
	bg_swap_pkg::swap_status_type   seq_status;

	function automatic logic hit(input logic [bg_swap_pkg::addr_width-1:0] a,
		input logic [9:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	// ==========================================================
	// APB decode; answer one cycle after the first access cycle
	wire                            access  = psel && penable;
	wire                            wr      = access && pwrite && pstrb[0];
	wire                            sel_c   = hit(paddr, bg_swap_pkg::idx_trim_c);
	wire                            sel_d   = hit(paddr, bg_swap_pkg::idx_trim_d);
	wire                            sel_ov  = hit(paddr, bg_swap_pkg::idx_overlap);
	wire                            sel_mx  = hit(paddr, bg_swap_pkg::idx_mux_delay);
	wire                            sel_dt  = hit(paddr, bg_swap_pkg::idx_dither_control);
	wire                            sel_ls  = hit(paddr, bg_swap_pkg::idx_lsb_control);
	wire                            mapped  = sel_c | sel_d | sel_ov | sel_mx | sel_dt | sel_ls;
	wire  [7:0]                     read_byte = sel_c ? input_c_termination_trim
		: sel_d  ? input_d_termination_trim
		: sel_ov ? swap_overlap_delay
		: sel_mx ? swap_mux_select_delay
		: sel_dt ? dither_control
		: sel_ls ? sample_lsb_control_output
		: 8'h00;
	wire  [7:0]                     wbyte   = pwdata[7:0];
	wire                            first   = access && !pready;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= first;
			pslverr <= first && !mapped;
			prdata  <= (first && !pwrite) ? {24'h00_0000, read_byte} : 32'h0000_0000;
		end
	end

	wire                            commit = wr && pready;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			input_c_termination_trim  <= 8'h00;
			input_d_termination_trim  <= 8'h00;
			trim_loaded               <= 1'b0;
		end else if (!trim_loaded) begin
			input_c_termination_trim  <= factory_trim_c;
			input_d_termination_trim  <= factory_trim_d;
			trim_loaded               <= 1'b1;
		end else begin
			if (commit && sel_c) input_c_termination_trim <= wbyte;
			if (commit && sel_d) input_d_termination_trim <= wbyte;
		end
	end

	// Full byte stored so reserved bits read back as written
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			swap_overlap_delay        <= bg_swap_pkg::overlap_reset;
			swap_mux_select_delay     <= bg_swap_pkg::mux_delay_reset;
			dither_control            <= bg_swap_pkg::dither_reset;
			sample_lsb_control_output <= bg_swap_pkg::lsb_reset;
		end else begin
			if (commit && sel_ov) swap_overlap_delay        <= wbyte;
			if (commit && sel_mx) swap_mux_select_delay     <= wbyte;
			if (commit && sel_dt) dither_control            <= wbyte;
			if (commit && sel_ls) sample_lsb_control_output <= wbyte;
		end
	end

	// ==========================================================
	// Swap sequencer
	wire  bg_swap_pkg::swap_timing_type timing = '{
		overlap:   swap_overlap_delay[bg_swap_pkg::delay_width-1:0],
		mux_delay: swap_mux_select_delay[bg_swap_pkg::delay_width-1:0]
	};

	swap_sequencer sequencer (
		.clk_sys      (clk_sys),
		.nrst         (nrst),
		.swap_request (swap_request),
		.timing       (timing),
		.status       (seq_status)
	);

	// ==========================================================
	// Outputs to the converter cores, all registered
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			input_c_trim   <= 8'h00;
			input_d_trim   <= 8'h00;
			dither_setting <= '0;
			swap_status    <= '0;
			lsb_control    <= 8'h00;
		end else begin
			input_c_trim   <= input_c_termination_trim;
			input_d_trim   <= input_d_termination_trim;
			dither_setting.enable          <= dither_control[bg_swap_pkg::dither_enable_bit];
			dither_setting.large_amplitude <= dither_control[bg_swap_pkg::dither_amp_bit];
			dither_setting.error_to_offset <= dither_control[bg_swap_pkg::dither_err_bit];
			swap_status    <= seq_status;
			lsb_control    <= sample_lsb_control_output;
		end
	end
endmodule

// [verification/bg_swap_assertions.sv]
`timescale 1ns/1ps
// ==========================================================
// Port checker
module bg_swap_assertions (
	input wire logic                       clk_sys,
	input wire logic                       nrst,
	input wire logic [11:0]                paddr,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [31:0]                prdata,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire bg_swap_pkg::swap_status_type swap_status
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire       acc = psel && penable && !pready;
	wire [9:0] ix  = paddr[11:2];
	wire       hit = paddr[1:0] == 2'h0 && (ix == bg_swap_pkg::idx_trim_c
		|| ix == bg_swap_pkg::idx_trim_d || ix == bg_swap_pkg::idx_overlap
		|| ix == bg_swap_pkg::idx_mux_delay || ix == bg_swap_pkg::idx_lsb_control
		|| ix == bg_swap_pkg::idx_dither_control);
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	ready_wait_a: assert property (acc |=> pready)
		else $error("no answer one cycle after access");
	ready_cause_a: assert property (pready |-> $past(acc))
		else $error("pready without an access");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr outside answer cycle");
	unmapped_err_a: assert property (acc && !hit |=> pslverr)
		else $error("unmapped address not refused");
	mapped_ok_a: assert property (acc && hit |=> !pslverr)
		else $error("mapped address refused");
	read_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	overlap_min_a: assert property ($rose(swap_status.both_sampling) |->
		swap_status.both_sampling [*4]) else $error("overlap shorter than four");
	sample_in_swap_a: assert property (swap_status.both_sampling |->
		swap_status.active) else $error("overlap outside a swap");
	cover property ($rose(swap_status.active));
	cover property (pready && pslverr);
	cover property (pready && pwrite && hit);
endmodule

// [verification/bg_swap_dither_control_tb.sv]
`timescale 1ns/1ps
module bg_swap_dither_control_tb;
	logic        clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, swap_request = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0]  pstrb = 4'h0;
	logic [7:0]  fc = 8'h5a, fd = 8'ha5, tc, td, lsb;
	logic        pready, pslverr;
	bg_swap_pkg::dither_setting_type ds;
	bg_swap_pkg::swap_status_type    ss;
	int          n_fail = 0, tests_run = 0;
	always #5 clk_sys = ~clk_sys;
	bg_swap_dither_control bg_swap_dither_control_inst (.clk_sys(clk_sys), .nrst(nrst),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.factory_trim_c(fc), .factory_trim_d(fd), .swap_request(swap_request),
		.input_c_trim(tc), .input_d_trim(td), .dither_setting(ds), .swap_status(ss),
		.lsb_control(lsb));
	// ==========================================================
	// Shared tasks
	task chk(input logic [32:0] s, input logic [32:0] e);
		tests_run++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task print_verdict;
		$display("fails=%0d checks=%0d", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task bus(input logic w, input logic [9:0] ix, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] rd, output logic e);
		@(posedge clk_sys);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= {ix, 2'b00}; pwdata <= d; pstrb <= s;
		@(posedge clk_sys);
		penable <= 1;
		// Waits for the slave; only the watchdog ends a hang
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rchk(input logic [9:0] ix, input logic [7:0] x, input logic err);
		logic [31:0] d;
		logic        e;
		bus(0, ix, 32'h0, 4'h0, d, e);
		chk({e, d}, {err, 24'h0, x});
	endtask
	task wr(input logic [9:0] ix, input logic [7:0] x, input logic [3:0] s);
		logic [31:0] d;
		logic        e;
		bus(1, ix, {24'h0, x}, s, d, e);
	endtask
	task swap_run(output int n, output int k);
		int   t;
		logic m;
		t = 0; n = 0; k = 0;
		m = ss.mux_select;
		@(posedge clk_sys) swap_request <= 1;
		@(posedge clk_sys) swap_request <= 0;
		while (ss.both_sampling !== 1'b1 && t < 50) begin @(posedge clk_sys); t++; end
		while (ss.both_sampling === 1'b1 && n < 100) begin @(posedge clk_sys); n++; end
		while (ss.mux_select === m && k < 100) begin @(posedge clk_sys); k++; end
		while (ss.active === 1'b1 && t < 300) begin @(posedge clk_sys); t++; end
		repeat (3) @(posedge clk_sys);
		chk({31'h0, ss.active, ss.mux_select}, {31'h0, 1'b0, ~m});
	endtask
	// ==========================================================
	// Scenarios
	task t_reset;
		rchk(bg_swap_pkg::idx_trim_c, fc, 0);
		rchk(bg_swap_pkg::idx_trim_d, fd, 0);
		rchk(bg_swap_pkg::idx_overlap, 8'h08, 0);
		rchk(bg_swap_pkg::idx_mux_delay, 8'h07, 0);
		rchk(bg_swap_pkg::idx_dither_control, 8'h00, 0);
		rchk(bg_swap_pkg::idx_lsb_control, 8'h00, 0);
		chk({tc, td}, {fc, fd});
	endtask
	task t_swap;
		int n, k, k0;
		swap_run(n, k);
		chk(33'(n), 33'd20);
		wr(bg_swap_pkg::idx_overlap, 8'h00, 4'h1);
		swap_run(n, k);
		chk(33'(n), 33'd4);
		wr(bg_swap_pkg::idx_overlap, 8'h1f, 4'h1);
		wr(bg_swap_pkg::idx_mux_delay, 8'h02, 4'h1);
		// Rewrite both delays while the long swap runs
		fork
			swap_run(n, k);
			begin
				repeat (8) @(posedge clk_sys);
				wr(bg_swap_pkg::idx_overlap, 8'h00, 4'h1);
				wr(bg_swap_pkg::idx_mux_delay, 8'h09, 4'h1);
			end
		join
		chk(33'(n), 33'd66);
		k0 = k;
		// Mux delay plus delay line output register plus one status stage
		chk(33'(k0), 33'd4);
		swap_run(n, k);
		chk(33'(n), 33'd4);
		chk(33'(k - k0), 33'd7);
		wr(bg_swap_pkg::idx_overlap, 8'h07, 4'h1);
		swap_run(n, k);
		chk(33'(n), 33'd18);
	endtask
	task t_rw;
		logic [9:0]  ix[6];
		logic [7:0]  v[6];
		logic [31:0] d;
		logic        e;
		ix = '{bg_swap_pkg::idx_trim_c, bg_swap_pkg::idx_trim_d, bg_swap_pkg::idx_overlap,
			bg_swap_pkg::idx_mux_delay, bg_swap_pkg::idx_dither_control,
			bg_swap_pkg::idx_lsb_control};
		// Written bytes read back; none of them sets a reserved bit
		v = '{8'hf1, 8'hf2, 8'h13, 8'h14, 8'h05, 8'h01};
		for (int i = 0; i < 6; i++) begin
			wr(ix[i], v[i], 4'h1);
			rchk(ix[i], v[i], 0);
		end
		chk({tc, td, lsb}, {8'hf1, 8'hf2, 8'h01});
		wr(ix[0], 8'h00, 4'h0);
		rchk(ix[0], 8'hf1, 0);
		bus(1, 10'h09c, 32'h0000_0033, 4'h1, d, e);
		chk(33'(e), 33'd1);
		rchk(10'h09c, 8'h00, 1);
	endtask
	task t_dither;
		for (int i = 0; i < 8; i++) begin
			wr(bg_swap_pkg::idx_dither_control, 8'(i), 4'h1);
			repeat (2) @(posedge clk_sys);
			chk(33'(ds), {30'h0, i[0], i[1], i[2]});
		end
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		nrst <= 1;
		repeat (2) @(posedge clk_sys);
		t_reset;
		t_swap;
		t_rw;
		t_dither;
		print_verdict;
	end
	initial begin
		#50000;
		n_fail++;
		print_verdict;
	end
endmodule
bind bg_swap_dither_control bg_swap_assertions bg_swap_assertions_inst (.clk_sys(clk_sys),
	.nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .swap_status(swap_status));
